/* File: design/sci_i2c_top.sv */
// two-wire bus mode of serial channel three: registers, bit engine, pins
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// ****************************************************************

module sci_i2c_top (
  // clock, reset and enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // register port
  input  wire sci_pkg::sci_bus_req_s bus_req,
  output var  logic [15:0]           rd_data,
  // clock pin
  input  wire logic                  scl_in,
  output var  logic                  scl_out,
  output var  logic                  scl_oe,
  // data pin
  input  wire logic                  sda_in,
  output var  logic                  sda_out,
  output var  logic                  sda_oe
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]         tb_r;
  logic [7:0]         brg_r;
  logic [7:0]         mode_r;
  logic [7:0]         c0_r;
  logic               te_r;
  logic               re_r;
  logic               irs_r;
  logic               ti_r;
  logic               ri_r;
  logic [1:0]         smr_r;
  logic               bbs_r;
  logic [7:0]         smr2_r;
  logic [7:0]         smr3_r;
  logic [7:0]         rb_data_r;
  logic               rb_ack_r;
  logic               ack_smp_r;
  logic               abt_r;
  logic               oer_r;
  logic               arb_pend_r;
  logic               lost_r;
  logic               active_r;
  logic [3:0]         bit_r;
  logic [7:0]         sh_r;
  logic [7:0]         rx_sh_r;
  logic               hold_r;
  logic               scl_m_r, scl_s_r, scl_d_r;
  logic               sda_m_r, sda_s_r, sda_d_r;
  logic [15:0]        rd_nxt;
  sci_pkg::sci_mclk_e mst_r;
  sci_pkg::sci_rate_s ticks;
  logic               sda_dly;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic wr, rd, bus_mode, master, slave;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_go, rx_load, eighth, arb_miss, reinit;
  logic rate_run, rate_clr;

  function automatic logic hit(input logic strobe, input logic [3:0] ofs);
    hit = strobe && (bus_req.addr == ofs);
  endfunction

  assign wr       = ce && bus_req.wr;
  assign rd       = ce && bus_req.rd;
  // role and mode only take effect with both mode selects set
  assign bus_mode = (mode_r[2:0] == sci_pkg::MODE_I2C) && smr_r[sci_pkg::SMR_TWO_WIRE_MODE_SELECT];
  assign master   = bus_mode && !mode_r[sci_pkg::MODE_CLOCK_SOURCE_DIRECTION];
  assign slave    = bus_mode && mode_r[sci_pkg::MODE_CLOCK_SOURCE_DIRECTION];

  // edges seen on the synchronised lines only
  assign scl_rise  = scl_s_r && !scl_d_r;
  assign scl_fall  = !scl_s_r && scl_d_r;
  assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_det  = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

  // a write in the same cycle would race the load, so it waits
  assign byte_go  = bus_mode && !active_r && te_r && !ti_r && !hit(wr, sci_pkg::OFS_TX_BUF);
  assign eighth   = active_r && scl_rise && (bit_r == 4'h7);
  assign rx_load  = active_r && (smr2_r[sci_pkg::SMR2_TWO_WIRE_IRQ_SELECT]
                                 ? (scl_fall && bit_r == sci_pkg::BIT_ACKDONE)
                                 : (scl_rise && bit_r == sci_pkg::BIT_LAST));
  assign arb_miss = master && active_r && scl_rise && (bit_r < sci_pkg::BIT_LAST)
                    && sh_r[7] && !sda_s_r;
  assign reinit   = slave && smr2_r[sci_pkg::SMR2_SLAVE_REINIT_ON_START] && start_det;

  // csc pauses the high phase while another master holds the line low
  assign rate_run = master && (mst_r != sci_pkg::SCI_M_IDLE)
                    && !(smr2_r[sci_pkg::SMR2_CSC] && mst_r == sci_pkg::SCI_M_HIGH && !scl_s_r);
  assign rate_clr = (mst_r == sci_pkg::SCI_M_IDLE)
                    || (smr2_r[sci_pkg::SMR2_CSC] && mst_r == sci_pkg::SCI_M_HIGH && scl_fall);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // three flops per pin; the first is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else if (ce) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_in, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // plain setup; transmit buffer and rate divisor are write-only; handshake bits are stored but steer nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_r   <= sci_pkg::RST_BYTE;
      brg_r  <= sci_pkg::RST_BYTE;
      mode_r <= sci_pkg::RST_BYTE;
      c0_r   <= sci_pkg::RST_BYTE;
      smr_r  <= 2'h0;
      smr2_r <= sci_pkg::RST_BYTE;
      smr3_r <= sci_pkg::RST_BYTE;
      te_r   <= 1'b0;
      re_r   <= 1'b0;
      irs_r  <= 1'b0;
    end else if (wr) begin
      unique case (bus_req.addr)
        sci_pkg::OFS_TX_BUF: tb_r   <= bus_req.wdata[7:0];
        sci_pkg::OFS_BRG:    brg_r  <= bus_req.wdata[7:0];
        sci_pkg::OFS_MODE:   mode_r <= bus_req.wdata[7:0];
        sci_pkg::OFS_CTRL0:  c0_r   <= bus_req.wdata[7:0];
        sci_pkg::OFS_SMR1:   smr_r  <= bus_req.wdata[1:0];
        sci_pkg::OFS_SMR2:   smr2_r <= bus_req.wdata[7:0];
        sci_pkg::OFS_SMR3:   smr3_r <= bus_req.wdata[7:0];
        sci_pkg::OFS_CTRL1: begin
          te_r  <= bus_req.wdata[sci_pkg::C1_TE];
          re_r  <= bus_req.wdata[sci_pkg::C1_RE];
          irs_r <= bus_req.wdata[4];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  // buffer empty: set when the byte moves to the shifter, cleared by a write
  always_ff @(posedge clk) begin
    if (rst) begin
      ti_r <= 1'b1;
    end else if (ce) begin
      if (byte_go) begin
        ti_r <= 1'b1;
      end else if (hit(wr, sci_pkg::OFS_TX_BUF)) begin
        ti_r <= 1'b0;
      end
    end
  end

  // reception complete: load sets, reading the buffer clears, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ri_r <= 1'b0;
    end else if (ce) begin
      if (rx_load && re_r && !ri_r) begin
        ri_r <= 1'b1;
      end else if (hit(rd, sci_pkg::OFS_RX_BUF)) begin
        ri_r <= 1'b0;
      end
    end
  end

  // overrun: eighth bit of a new byte with the old one unread
  always_ff @(posedge clk) begin
    if (rst) begin
      oer_r <= 1'b0;
    end else if (ce) begin
      if (eighth && re_r && ri_r) begin
        oer_r <= 1'b1;
      end else if (hit(wr, sci_pkg::OFS_CTRL1) && !bus_req.wdata[sci_pkg::C1_RE]) begin
        oer_r <= 1'b0;
      end
    end
  end

  // receive buffer: an unread byte is never overwritten
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_data_r <= sci_pkg::RST_BYTE;
      rb_ack_r  <= 1'b0;
    end else if (ce && rx_load && re_r && !ri_r) begin
      rb_data_r <= rx_sh_r;
      rb_ack_r  <= rb_ack_nxt();
    end
  end

  // ack level of the ninth clock; on the rise itself the sampler is a cycle late
  function automatic logic rb_ack_nxt();
    rb_ack_nxt = smr2_r[sci_pkg::SMR2_TWO_WIRE_IRQ_SELECT] ? ack_smp_r : sda_s_r;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_smp_r <= 1'b0;
    end else if (ce && active_r && scl_rise && bit_r == sci_pkg::BIT_LAST) begin
      ack_smp_r <= sda_s_r;
    end
  end

  // arbitration: abc=0 flags at once, abc=1 at the ninth rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      abt_r      <= 1'b0;
      arb_pend_r <= 1'b0;
    end else if (ce) begin
      if (arb_miss) begin
        arb_pend_r <= 1'b1;
      end else if (scl_rise && bit_r == sci_pkg::BIT_LAST) begin
        arb_pend_r <= 1'b0;
      end
      if ((arb_miss && !smr_r[sci_pkg::SMR_ABC])
          || (master && arb_pend_r && scl_rise && bit_r == sci_pkg::BIT_LAST)) begin
        abt_r <= 1'b1;
      end else if (hit(wr, sci_pkg::OFS_RX_BUF) && !bus_req.wdata[sci_pkg::RB_ABT]) begin
        abt_r <= 1'b0;
      end
    end
  end

  // bus busy follows the conditions seen on the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      bbs_r <= 1'b0;
    end else if (ce && bus_mode) begin
      if (start_det) begin
        bbs_r <= 1'b1;
      end else if (stop_det) begin
        bbs_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // bit engine
  // ****************************************************************
  // rising edges sample, falling edges shift; byte ends on ninth fall
  always_ff @(posedge clk) begin
    if (rst) begin
      active_r <= 1'b0;
      bit_r    <= 4'h0;
      sh_r     <= sci_pkg::RST_SHIFT;
      rx_sh_r  <= sci_pkg::RST_BYTE;
      lost_r   <= 1'b0;
    end else if (ce) begin
      if (reinit || !bus_mode) begin
        active_r <= 1'b0;
        bit_r    <= 4'h0;
        sh_r     <= sci_pkg::RST_SHIFT;
        lost_r   <= 1'b0;
      end else if (byte_go) begin
        active_r <= 1'b1;
        bit_r    <= 4'h0;
        sh_r     <= tb_r;
        lost_r   <= 1'b0;
      end else if (active_r && scl_rise) begin
        bit_r <= bit_r + 4'h1;
        if (bit_r < sci_pkg::BIT_LAST) begin
          rx_sh_r <= {rx_sh_r[6:0], sda_s_r};
        end
        if (arb_miss) begin
          lost_r <= 1'b1;
        end
      end else if (active_r && scl_fall) begin
        if (bit_r == sci_pkg::BIT_ACKDONE) begin
          active_r <= 1'b0;
          bit_r    <= 4'h0;
          sh_r     <= sci_pkg::RST_SHIFT;
          lost_r   <= 1'b0;
        end else if (bit_r != 4'h0) begin
          sh_r <= {sh_r[6:0], 1'b1}; // ack slot shifts in a released level
        end
      end
    end
  end

  // clock hold from the ninth falling edge until new data or bit cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (ce) begin
      if (smr2_r[sci_pkg::SMR2_SWC] && active_r && scl_fall && bit_r == sci_pkg::BIT_ACKDONE) begin
        hold_r <= 1'b1;
      end else if (!smr2_r[sci_pkg::SMR2_SWC] || hit(wr, sci_pkg::OFS_TX_BUF) || reinit) begin
        hold_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // master clock generator
  // ****************************************************************
  // low and high phases each last one half period of the rate generator
  always_ff @(posedge clk) begin
    if (rst || !master) begin
      mst_r <= sci_pkg::SCI_M_IDLE;
    end else if (ce) begin
      unique case (mst_r)
        sci_pkg::SCI_M_IDLE: if (byte_go) begin
          mst_r <= sci_pkg::SCI_M_LOW;
        end
        sci_pkg::SCI_M_LOW: if (ticks.half_tick && !hold_r) begin
          mst_r <= active_r ? sci_pkg::SCI_M_HIGH : sci_pkg::SCI_M_IDLE;
        end
        sci_pkg::SCI_M_HIGH: begin
          if (ticks.half_tick || (smr2_r[sci_pkg::SMR2_CSC] && scl_fall)) begin
            mst_r <= sci_pkg::SCI_M_LOW;
          end
        end
      endcase
    end
  end

  sci_rate_gen u_rate (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .src_sel (c0_r[1:0]),
    .divisor (brg_r),
    .run     (rate_run),
    .clr     (rate_clr),
    .ticks   (ticks)
  );

  // data low request passes the digital delay before the pin
  sci_sda_delay u_dly (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .tick (ticks.src_tick),
    .dly  (smr3_r[sci_pkg::SMR3_DL_LO +: 3]),
    .din  (active_r && !sh_r[7]),
    .dout (sda_dly)
  );

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // open drain: the pin level is always 0, only the enable moves
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce) begin
      scl_oe <= bus_mode && (smr2_r[sci_pkg::SMR2_CLOCK_FORCE_LOW]
                             || hold_r
                             || mst_r == sci_pkg::SCI_M_LOW);
      sda_oe <= bus_mode && sda_dly
                && !smr2_r[sci_pkg::SMR2_DATA_LINE_RELEASE]
                && !(master && smr2_r[sci_pkg::SMR2_ALS] && lost_r);
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // unmapped offsets read as zero
  always_comb begin
    rd_nxt = sci_pkg::RST_WORD;
    unique case (bus_req.addr)
      sci_pkg::OFS_RX_BUF: begin
        rd_nxt[7:0]             = rb_data_r;
        rd_nxt[sci_pkg::RB_ACK] = rb_ack_r;
        rd_nxt[sci_pkg::RB_ABT] = abt_r;
        rd_nxt[sci_pkg::RB_OER] = oer_r;
      end
      sci_pkg::OFS_MODE:  rd_nxt[7:0] = mode_r;
      sci_pkg::OFS_CTRL0: begin
        rd_nxt[7:0]                = c0_r;
        rd_nxt[sci_pkg::C0_SHIFT_REGISTER_EMPTY]  = !active_r;
      end
      sci_pkg::OFS_CTRL1: begin
        rd_nxt[sci_pkg::C1_TE] = te_r;
        rd_nxt[sci_pkg::C1_TI] = ti_r;
        rd_nxt[sci_pkg::C1_RE] = re_r;
        rd_nxt[sci_pkg::C1_RI] = ri_r;
        rd_nxt[4]              = irs_r;
      end
      sci_pkg::OFS_SMR1: begin
        rd_nxt[1:0]              = smr_r;
        rd_nxt[sci_pkg::SMR_BBS] = bbs_r;
      end
      sci_pkg::OFS_SMR2: rd_nxt[7:0] = smr2_r;
      sci_pkg::OFS_SMR3: rd_nxt[7:0] = smr3_r;
      default: ;
    endcase
  end

  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= sci_pkg::RST_WORD;
    end else if (ce) begin
      rd_data <= rd ? rd_nxt : sci_pkg::RST_WORD;
    end
  end

endmodule

`default_nettype wire

/* File: design/sci_pkg.sv */
// shared constants and carrier types for the two-wire serial channel
package sci_pkg;

  // ****************************************************************
  // register offsets on the plain register port
  // ****************************************************************
  localparam logic [3:0] OFS_TX_BUF  = 4'h0;
  localparam logic [3:0] OFS_RX_BUF  = 4'h1;
  localparam logic [3:0] OFS_BRG     = 4'h2;
  localparam logic [3:0] OFS_MODE    = 4'h3;
  localparam logic [3:0] OFS_CTRL0   = 4'h4;
  localparam logic [3:0] OFS_CTRL1   = 4'h5;
  localparam logic [3:0] OFS_SMR1    = 4'h6;
  localparam logic [3:0] OFS_SMR2    = 4'h7;
  localparam logic [3:0] OFS_SMR3    = 4'h8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MODE_CLOCK_SOURCE_DIRECTION   = 3;   // clock_source_direction
  localparam int C0_SHIFT_REGISTER_EMPTY     = 3;   // shift_register_empty
  localparam int C1_TE        = 0;   // transmit_enable_bit
  localparam int C1_TI        = 1;   // tx_buffer_empty
  localparam int C1_RE        = 2;   // rx_enable_bit
  localparam int C1_RI        = 3;   // rx_done_flag
  localparam int SMR_TWO_WIRE_MODE_SELECT     = 0;   // two_wire_mode_select
  localparam int SMR_ABC      = 1;   // arb_loss_timing_select
  localparam int SMR_BBS      = 2;   // bus_busy_flag
  localparam int SMR2_TWO_WIRE_IRQ_SELECT   = 0;
  localparam int SMR2_CSC     = 1;
  localparam int SMR2_SWC     = 2;
  localparam int SMR2_ALS     = 3;
  localparam int SMR2_SLAVE_REINIT_ON_START    = 4;
  localparam int SMR2_CLOCK_FORCE_LOW    = 5;
  localparam int SMR2_DATA_LINE_RELEASE    = 6;
  localparam int SMR3_DL_LO   = 5;   // data_delay_field, bits 7..5
  localparam int RB_ACK       = 8;
  localparam int RB_ABT       = 11;  // arb_lost_flag
  localparam int RB_OER       = 12;  // overrun_flag

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  RST_SHIFT   = 8'hFF;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [2:0]  MODE_I2C    = 3'h2;
  localparam logic [3:0]  BIT_LAST    = 4'h8;
  localparam logic [3:0]  BIT_ACKDONE = 4'h9;

  // count source prescale terminals: f1, f2, f8, f32
  localparam logic [4:0] PRE_F1  = 5'h00;
  localparam logic [4:0] PRE_F2  = 5'h01;
  localparam logic [4:0] PRE_F8  = 5'h07;
  localparam logic [4:0] PRE_F32 = 5'h1F;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {SCI_M_IDLE, SCI_M_LOW, SCI_M_HIGH} sci_mclk_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sci_bus_req_s;

  typedef struct packed {
    logic src_tick;
    logic half_tick;
  } sci_rate_s;

endpackage

/* File: design/sci_rate_gen.sv */
// transfer-rate generator: count source prescaler and 8-bit divider
`timescale 1ns/10ps
`default_nettype none

module sci_rate_gen (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // setup
  input  wire logic [1:0]         src_sel,
  input  wire logic [7:0]         divisor,
  input  wire logic               run,
  input  wire logic               clr,
  // ticks
  output var  sci_pkg::sci_rate_s ticks
);

  logic [4:0] pre_r;
  logic [7:0] div_r;
  logic [4:0] pre_term;

  // count source terminal count
  always_comb begin
    unique case (src_sel)
      2'h0: pre_term = sci_pkg::PRE_F1;
      2'h1: pre_term = sci_pkg::PRE_F2;
      2'h2: pre_term = sci_pkg::PRE_F8;
      2'h3: pre_term = sci_pkg::PRE_F32;
    endcase
  end

  // prescaler free-runs so the data delay has a time base in both roles
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r          <= 5'h00;
      ticks.src_tick <= 1'b0;
    end else if (ce) begin
      ticks.src_tick <= (pre_r == pre_term);
      pre_r          <= (pre_r >= pre_term) ? 5'h00 : pre_r + 5'h01;
    end
  end

  // n+1 source ticks per half period gives fj/(2(n+1))
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r           <= 8'h00;
      ticks.half_tick <= 1'b0;
    end else if (ce) begin
      ticks.half_tick <= 1'b0;
      if (clr) begin
        div_r <= 8'h00;
      end else if (run && pre_r == pre_term) begin
        if (div_r == divisor) begin
          div_r           <= 8'h00;
          ticks.half_tick <= 1'b1;
        end else begin
          div_r <= div_r + 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: design/sci_sda_delay.sv */
// digital delay line on the data output, stepped by the count source
`timescale 1ns/10ps
`default_nettype none

module sci_sda_delay (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       tick,
  input  wire logic [2:0] dly,
  // data
  input  wire logic       din,
  output var  logic       dout
);

  logic [7:0] tap_r;

  // taps advance once per count source cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tap_r <= 8'h00;
    end else if (ce && tick) begin
      tap_r <= {tap_r[6:0], din};
    end
  end

  // code 0 bypasses, codes 1..7 pick 2..8 source cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (ce) begin
      dout <= (dly == 3'h0) ? din : tap_r[dly];
    end
  end

endmodule

`default_nettype wire

/* File: testbench/sci_chk.sv */
// port checker for the two-wire serial channel
`timescale 1ns/10ps
`default_nettype none
module sci_chk (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  // register port
  input wire sci_pkg::sci_bus_req_s bus_req,
  input wire logic [15:0]           rd_data,
  // pins
  input wire logic                  scl_in,
  input wire logic                  scl_out,
  input wire logic                  scl_oe,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe
);
  logic f_r;
  logic h_r;
  // shadow of forced-low and release bits; assumes ce stays high
  always_ff @(posedge clk) begin
    if (rst) begin
      {h_r, f_r} <= 2'h0;
    end else if (ce && bus_req.wr && bus_req.addr == sci_pkg::OFS_SMR2) begin
      {h_r, f_r} <= bus_req.wdata[6:5];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000) else $error("rd idle");
  a_rx_spare_zero: assert property ($past(bus_req.rd && bus_req.addr == sci_pkg::OFS_RX_BUF)
    |-> rd_data[15:13] == 3'h0 && rd_data[10:9] == 2'h0) else $error("rx spare");
  a_brg_upper_zero: assert property ($past(bus_req.rd && bus_req.addr == sci_pkg::OFS_BRG)
    |-> rd_data[15:8] == 8'h00) else $error("brg upper");
  a_ctrl_spare_zero: assert property ($past(bus_req.rd && bus_req.addr == sci_pkg::OFS_CTRL0)
    |-> rd_data[15:4] == 12'h000 && !rd_data[2]) else $error("ctrl0 spare");
  a_smr_spare_zero: assert property ($past(bus_req.rd && bus_req.addr == sci_pkg::OFS_SMR1)
    |-> rd_data[15:3] == 13'h0000) else $error("smr spare");
  a_force_low: assert property (f_r [*3] |-> scl_oe) else $error("scl force");
  a_data_release: assert property (h_r [*3] |-> !sda_oe) else $error("sda release");
  a_pin_out_low: assert property (!scl_out && !sda_out) else $error("pin out");
endmodule
bind sci_i2c_top sci_chk u_chk (.*);
`default_nettype wire

/* File: testbench/sci_peer.sv */
// bus peer: acks each byte, may stretch the clock or fight on bit 7
`timescale 1ns/10ps
`default_nettype none
module sci_peer (
  // clock and lines
  input wire logic  clk,
  input wire logic  scl,
  input wire logic  sda,
  // behaviour
  input wire logic  slow,
  input wire logic  fight,
  // drivers
  output var logic  scl_oe,
  output var logic  sda_oe
);
  logic [3:0] n_r = 4'h0; // falls seen in this byte
  logic [6:0] w_r = 7'h00; // stretch countdown
  logic       s_r = 1'b1; // last clock level
  // count falls; ten per byte, the first one before the top bit
  always @(posedge clk) begin
    s_r <= scl;
    // stretch outlasts the master's low phase so clock sync is exercised
    w_r <= (s_r && !scl && slow) ? 7'h50 : w_r - {6'h00, w_r != 7'h00};
    if (s_r && !scl) n_r <= (n_r == 4'h9) ? 4'h0 : n_r + 4'h1;
  end
  // ack slot low; a fight pulls the first data bit low
  assign sda_oe = (n_r == 4'h9) || (fight && n_r == 4'h1);
  assign scl_oe = w_r != 7'h00;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench of the two-wire serial channel
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ck = 1'b0, ck_d = 1'b0, slow = 1'b0, fight = 1'b0;
  sci_pkg::sci_bus_req_s q = '0;
  logic [15:0] rd_data, eq[$];
  logic        scl_out, scl_oe, sda_out, sda_oe, p_scl, p_sda;
  logic [7:0]  b, p;
  logic [2:0]  dl;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  wire logic   scl = !(scl_oe || p_scl); // pull-ups on both lines
  wire logic   sda = !(sda_oe || p_sda);
  always #4 clk = !clk;
  sci_i2c_top u_dut (.clk, .rst, .ce, .bus_req(q), .rd_data, .scl_in(scl), .scl_out, .scl_oe,
    .sda_in(sda), .sda_out, .sda_oe);
  sci_peer u_peer (.clk, .scl, .sda, .slow, .fight, .scl_oe(p_scl), .sda_oe(p_sda));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    q.addr <= a;
    q.wdata <= d;
    q.wr <= 1'b1;
    @(posedge clk);
    q.wr <= 1'b0;
  endtask
  // a checked read leaves its expectation for the monitor
  task automatic rd(input logic [3:0] a, input logic c, input logic [15:0] e);
    @(posedge clk);
    q.addr <= a;
    q.rd <= 1'b1;
    ck <= c;
    if (c) eq.push_back(e);
    @(posedge clk);
    q.rd <= 1'b0;
    ck <= 1'b0;
  endtask
  task automatic poll(input logic [3:0] a, input int k);
    repeat (3000) begin
      rd(a, 1'b0, 16'h0000);
      @(negedge clk);
      if (rd_data[k] === 1'b1) return;
    end
    n_fail++;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    ck_d <= ck;
    cyc++;
    if (ck_d) cmp("read data", eq.pop_front(), rd_data);
    if (cyc == 60000) begin
      n_fail++;
      complete_run;
    end
  end
  // master setup, then plain, stretched, overrun and lost bytes
  initial begin
    void'($urandom(3959));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(sci_pkg::OFS_CTRL1, 1'b1, 16'h0002);
    rd(4'hF, 1'b1, 16'h0000);
    wr(sci_pkg::OFS_MODE, {13'h0000, sci_pkg::MODE_I2C});
    wr(sci_pkg::OFS_SMR1, 16'h0001);
    rd(sci_pkg::OFS_SMR1, 1'b1, 16'h0001);
    wr(sci_pkg::OFS_SMR2, 16'h0002);
    wr(sci_pkg::OFS_CTRL0, 16'($urandom % 2));
    // half period kept above the longest data delay plus pin latency
    wr(sci_pkg::OFS_BRG, 16'(24 + $urandom % 4));
    rd(sci_pkg::OFS_BRG, 1'b0, 16'h0000);
    dl = 3'($urandom);
    wr(sci_pkg::OFS_SMR3, {8'h00, dl, 5'h00});
    wr(sci_pkg::OFS_CTRL1, 16'h0005);
    rd(sci_pkg::OFS_CTRL1, 1'b1, 16'h0007);
    for (int k = 0; k < 5; k++) begin
      b = k == 4 ? 8'h00 : 8'($urandom) | {k == 3, 7'h00};
      slow <= k == 1;
      fight <= k == 3;
      if (k == 4) wr(sci_pkg::OFS_SMR2, 16'h0042);
      wr(sci_pkg::OFS_TX_BUF, {8'h00, b});
      repeat (4) @(posedge clk);
      poll(sci_pkg::OFS_CTRL0, sci_pkg::C0_SHIFT_REGISTER_EMPTY);
      poll(sci_pkg::OFS_CTRL1, sci_pkg::C1_RI);
      if (k != 1) rd(sci_pkg::OFS_RX_BUF, 1'b1, k == 0 ? {8'h00, b} : k == 2 ? {8'h10, p} :
        k == 3 ? {8'h08, b & 8'h7F} : 16'h08FF);
      if (k == 2) wr(sci_pkg::OFS_CTRL1, 16'h0001);
      if (k == 2) wr(sci_pkg::OFS_CTRL1, 16'h0005);
      p = b;
      // let the master go idle and the peer end its stretch before the next byte
      repeat (120) @(posedge clk);
    end
    wr(sci_pkg::OFS_SMR2, 16'h0022);
    repeat (6) @(posedge clk);
    cmp("clock line", 16'h0000, {15'h0000, scl});
    wr(sci_pkg::OFS_SMR2, 16'h0040);
    repeat (6) @(posedge clk);
    cmp("data enable", 16'h0000, {15'h0000, sda_oe});
    // a write while frozen must not land
    ce <= 1'b0;
    wr(sci_pkg::OFS_SMR3, {8'h00, ~dl, 5'h00});
    ce <= 1'b1;
    rd(sci_pkg::OFS_SMR3, 1'b1, {8'h00, dl, 5'h00});
    complete_run;
  end
endmodule
`default_nettype wire
